// File: pkg/vfomc_pkg.sv
// Purpose: shared constants and types of the oscillator frequency memory and display counter
// Assumes: 10 MHz system clock; crystal reference arrives as a pin
// Notes: counts are bcd, six digits, least significant digit in bits 3:0
package vfomc_pkg;
  localparam int CLK_MHZ = 10;
  localparam int XTAL_HZ = 3276800;
  localparam int GATE_HZ = 50;
  localparam int REF_HZ = 100;
  // crystal divider width; its top bit is the 50 Hz gate, the bit below it the 100 Hz reference
  localparam int XTAL_DIV_W = $clog2(XTAL_HZ / GATE_HZ);
  localparam int GATE_BIT = XTAL_DIV_W - 1;
  localparam int REF_BIT = $clog2(XTAL_HZ / REF_HZ) - 1;
  localparam int DIGITS = 6;
  localparam int BCD_W = 4 * DIGITS;
  localparam int CHAINS = 3;
  localparam int CH_MEAS = 0;
  localparam int CH_DISP = 1;
  localparam int CH_DIV = 2;
  localparam int NSYNC = 6;
  localparam int IN_XTAL = 0;
  localparam int IN_VFO = 1;
  localparam int IN_SUB = 2;
  localparam int IN_PREMIX = 3;
  localparam int IN_STORE = 4;
  localparam int IN_RECALL = 5;
  localparam logic [BCD_W-1:0] DIV_MIN = 24'h005000;
  localparam logic [BCD_W-1:0] DIV_MAX = 24'h055000;
  localparam logic [BCD_W-1:0] PRESET_RST = 24'h050000;
  localparam logic [BCD_W-1:0] BCD_ONE = 24'h000001;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam int ONESHOT_US = 100;
  localparam int ONESHOT_CYCLES = ONESHOT_US * CLK_MHZ;
  localparam int SCAN_US = 1000;
  localparam int SCAN_CYCLES_DEF = SCAN_US * CLK_MHZ;
  localparam logic [6:0] SEG_BLANK = 7'h00;
  typedef enum logic [1:0] {
    ST_WAIT_OPEN = 2'b00,
    ST_COUNT = 2'b01,
    ST_XFER = 2'b10,
    ST_CLEAR = 2'b11
  } vfomc_state_t;
endpackage : vfomc_pkg

// File: pkg/vfomc_digit_if.sv
// Purpose: control and result lines of one bcd decade stage
// Assumes: one instance per decade stage
// Notes: carry is combinational from the stage
`timescale 1ns/1ps
`default_nettype none
interface vfomc_digit_if;
  logic en;
  logic up;
  logic clr;
  logic load;
  logic [3:0] load_val;
  logic [3:0] val;
  logic carry;
  modport digit (input en, up, clr, load, load_val, output val, carry);
  modport ctrl (output en, up, clr, load, load_val, input val, carry);
endinterface : vfomc_digit_if
`default_nettype wire

// File: verilog/vfomc_decade.sv
// Purpose: one bcd decade stage, up or down, with clear and parallel load
// Assumes: clr beats load beats count
// Notes: carry doubles as borrow when counting down
`timescale 1ns/1ps
`default_nettype none
module vfomc_decade
  import vfomc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  vfomc_digit_if.digit d
);
  wire at_top = (d.val == BCD_NINE);
  wire at_bottom = (d.val == 4'h0);
  assign d.carry = d.en & (d.up ? at_top : at_bottom);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      d.val <= 4'h0;
    end else if (d.clr) begin
      d.val <= 4'h0;
    end else if (d.load) begin
      d.val <= d.load_val;
    end else if (d.en) begin
      if (d.up) begin
        d.val <= at_top ? 4'h0 : d.val + 4'h1;
      end else begin
        d.val <= at_bottom ? BCD_NINE : d.val - 4'h1;
      end
    end
  end
endmodule : vfomc_decade
`default_nettype wire

// File: verilog/vfomc_top.sv
// Purpose: oscillator frequency memory, substitute oscillator divider and display counter
// Assumes: all pin inputs asynchronous; oscillator inputs are far slower than clk_i/2
// Notes: window is the low half of the 50 Hz gate, 10 ms, so counts are in 100 Hz units
`timescale 1ns/1ps
`default_nettype none
// Contract
// - the crystal input is divided down to a 50 Hz gate that sets the counting window.
// - oscillator edges inside the window are counted by a six-digit decimal counter.
// - the bcd count passes through holding latches that preset the programmable down divider.
// - the divider divides substitute oscillator edges by the preset, held between 5000 and 55000.
// - the divider output is stretched by a one-shot and phase compared to a 100 Hz crystal ref.
// - a store press freezes the latched count so the substitute oscillator stays on it.
// - while recall is held the substitute oscillator replaces the variable one on the loop feed.
// - sequencing logic makes the clear and transfer pulses around each counting window.
// - the display shows six seven-segment digits multiplexed over shared segment lines.
// - the display counts the premix local oscillator, level controlled outside this block.
module vfomc_top
  import vfomc_pkg::*;
#(
  parameter int SCAN_CYCLES = SCAN_CYCLES_DEF,
  parameter int OS_CYCLES = ONESHOT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic xtal_ref_i,
  input wire logic variable_oscillator_i,
  input wire logic substitute_oscillator_i,
  input wire logic premix_lo_i,
  input wire logic memory_store_switch_i,
  input wire logic memory_recall_switch_i,
  output logic synth_feed_o,
  output logic recall_active_o,
  output logic stored_o,
  output logic divider_pulse_o,
  output logic phase_up_o,
  output logic phase_down_o,
  output logic [6:0] segment_o,
  output logic [DIGITS-1:0] digit_select_o
);
  if (SCAN_CYCLES < 2) begin : g_chk_scan
    $error("SCAN_CYCLES must be at least 2");
  end
  if (OS_CYCLES < 1 || OS_CYCLES >= SCAN_CYCLES_DEF * 100) begin : g_chk_os
    $error("OS_CYCLES out of range");
  end

  // every pin is brought in over two flops; edges are taken on the second stage only
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync_prev;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync_prev <= '0;
    end else begin
      sync1 <= {memory_recall_switch_i, memory_store_switch_i, premix_lo_i,
                substitute_oscillator_i, variable_oscillator_i, xtal_ref_i};
      sync2 <= sync1;
      sync_prev <= sync2;
    end
  end
  wire [NSYNC-1:0] rise = sync2 & ~sync_prev;

  // crystal timebase
  logic [XTAL_DIV_W-1:0] xtal_cnt;
  logic gate_prev;
  logic ref_prev;
  wire gate_open = ~xtal_cnt[GATE_BIT];
  wire gate_start = gate_open & ~gate_prev;
  wire ref_rise = xtal_cnt[REF_BIT] & ~ref_prev;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xtal_cnt <= '0;
      gate_prev <= 1'b0;
      ref_prev <= 1'b0;
    end else begin
      if (rise[IN_XTAL]) xtal_cnt <= xtal_cnt + 1'b1;
      gate_prev <= gate_open;
      ref_prev <= xtal_cnt[REF_BIT];
    end
  end

  // window sequencer
  vfomc_state_t state;
  vfomc_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      ST_WAIT_OPEN: if (gate_start) next_state = ST_COUNT;
      ST_COUNT: if (!gate_open) next_state = ST_XFER;
      ST_XFER: next_state = ST_CLEAR;
      ST_CLEAR: next_state = ST_WAIT_OPEN;
      default: next_state = ST_CLEAR;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) state <= ST_CLEAR;
    else state <= next_state;
  end
  wire counting = (state == ST_COUNT) & gate_open;
  wire xfer = (state == ST_XFER);
  wire clr_pulse = (state == ST_CLEAR);

  // three decade chains: measure, display, divider
  logic [CHAINS-1:0] base_en;
  logic [CHAINS-1:0] ch_up;
  logic [CHAINS-1:0] ch_clr;
  logic [CHAINS-1:0] ch_load;
  logic [BCD_W-1:0] ch_val [CHAINS];
  logic [BCD_W-1:0] preset_eff;
  vfomc_digit_if dif [CHAINS*DIGITS] ();
  for (genvar c = 0; c < CHAINS; c++) begin : g_chain
    for (genvar k = 0; k < DIGITS; k++) begin : g_dig
      localparam int I = c * DIGITS + k;
      if (k == 0) begin : g_lsd
        assign dif[I].en = base_en[c];
      end else begin : g_upper
        assign dif[I].en = dif[I-1].carry;
      end
      assign dif[I].up = ch_up[c];
      assign dif[I].clr = ch_clr[c];
      assign dif[I].load = ch_load[c];
      assign dif[I].load_val = preset_eff[4*k +: 4];
      assign ch_val[c][4*k +: 4] = dif[I].val;
      vfomc_decade u_dec (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d(dif[I])
      );
    end
  end

  assign base_en[CH_MEAS] = counting & rise[IN_VFO];
  assign base_en[CH_DISP] = counting & rise[IN_PREMIX];
  assign ch_up[CH_MEAS] = 1'b1;
  assign ch_up[CH_DISP] = 1'b1;
  assign ch_up[CH_DIV] = 1'b0;
  assign ch_clr[CH_MEAS] = clr_pulse;
  assign ch_clr[CH_DISP] = clr_pulse;
  assign ch_clr[CH_DIV] = 1'b0;
  assign ch_load[CH_MEAS] = 1'b0;
  assign ch_load[CH_DISP] = 1'b0;

  // holding latches; bcd order equals numeric order, so the clamp compares directly
  logic [BCD_W-1:0] result;
  logic [BCD_W-1:0] preset;
  logic [BCD_W-1:0] disp_hold;
  logic frozen;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result <= PRESET_RST;
      preset <= PRESET_RST;
      disp_hold <= '0;
      frozen <= 1'b0;
    end else begin
      if (xfer) begin
        result <= ch_val[CH_MEAS];
        disp_hold <= ch_val[CH_DISP];
      end
      if (rise[IN_STORE]) begin
        frozen <= 1'b1;
        preset <= result;
      end else if (xfer && !frozen) begin
        preset <= ch_val[CH_MEAS];
      end
    end
  end
  assign preset_eff = (preset < DIV_MIN) ? DIV_MIN :
                      (preset > DIV_MAX) ? DIV_MAX : preset;

  // programmable divider: counts preset down to one, then reloads
  wire div_terminal = (ch_val[CH_DIV] <= BCD_ONE);
  wire div_tc = rise[IN_SUB] & div_terminal;
  assign ch_load[CH_DIV] = div_tc;
  assign base_en[CH_DIV] = rise[IN_SUB] & ~div_terminal;

  // one-shot stretch and phase-frequency comparator
  logic [$clog2(OS_CYCLES+1)-1:0] os_cnt;
  logic [2:0] pfd_next;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      os_cnt <= '0;
      divider_pulse_o <= 1'b0;
      phase_up_o <= 1'b0;
      phase_down_o <= 1'b0;
    end else begin
      if (div_tc) os_cnt <= ($clog2(OS_CYCLES+1))'(OS_CYCLES);
      else if (os_cnt != '0) os_cnt <= os_cnt - 1'b1;
      divider_pulse_o <= div_tc | (os_cnt > ($clog2(OS_CYCLES+1))'(1));
      phase_up_o <= pfd_next[0];
      phase_down_o <= pfd_next[1];
    end
  end
  wire up_set = phase_up_o | ref_rise;
  wire dn_set = phase_down_o | div_tc;
  // both set means both edges seen: release together, as a tri-state detector does
  assign pfd_next = {1'b0, dn_set & ~up_set, up_set & ~dn_set};

  // display multiplexing
  logic [$clog2(SCAN_CYCLES)-1:0] scan_cnt;
  logic [$clog2(DIGITS)-1:0] scan_idx;
  wire scan_step = (scan_cnt == ($clog2(SCAN_CYCLES))'(SCAN_CYCLES - 1));
  wire [3:0] cur_nib = disp_hold[4*scan_idx +: 4];
  logic [6:0] seg_dec;
  always_comb begin
    case (cur_nib)
      4'h0: seg_dec = 7'h3f;
      4'h1: seg_dec = 7'h06;
      4'h2: seg_dec = 7'h5b;
      4'h3: seg_dec = 7'h4f;
      4'h4: seg_dec = 7'h66;
      4'h5: seg_dec = 7'h6d;
      4'h6: seg_dec = 7'h7d;
      4'h7: seg_dec = 7'h07;
      4'h8: seg_dec = 7'h7f;
      4'h9: seg_dec = 7'h6f;
      default: seg_dec = SEG_BLANK;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scan_cnt <= '0;
      scan_idx <= '0;
      segment_o <= SEG_BLANK;
      digit_select_o <= '0;
    end else begin
      scan_cnt <= scan_step ? '0 : scan_cnt + 1'b1;
      if (scan_step) begin
        scan_idx <= (scan_idx == ($clog2(DIGITS))'(DIGITS - 1)) ? '0 : scan_idx + 1'b1;
      end
      segment_o <= seg_dec;
      digit_select_o <= DIGITS'(1) << scan_idx;
    end
  end

  // loop feed selection; recall is a held level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      synth_feed_o <= 1'b0;
      recall_active_o <= 1'b0;
      stored_o <= 1'b0;
    end else begin
      synth_feed_o <= sync2[IN_RECALL] ? sync2[IN_SUB] : sync2[IN_VFO];
      recall_active_o <= sync2[IN_RECALL];
      stored_o <= frozen;
    end
  end
endmodule : vfomc_top
`default_nettype wire

// File: tb/vfomc_osc_model.sv
// Purpose: far-side oscillators feeding vfomc_top
// Assumes: crystal sped up to a 4 clk period so the timebase fits a short run
// Notes: vfo and premix free-run at unrelated rates
`timescale 1ns/1ps
`default_nettype none
module vfomc_osc_model (
  input wire logic clk_i,
  output logic xtal_o,
  output logic vfo_o,
  output logic premix_o
);
  int n;
  initial begin
    n = 0;
    xtal_o = 1'b0;
    vfo_o = 1'b0;
    premix_o = 1'b0;
  end
  always @(negedge clk_i) begin
    n <= n + 1;
    // crystal reference, the only time source of gate and phase
    if (n % 2 == 1) xtal_o <= !xtal_o;
    if (n % 7 == 0) vfo_o <= !vfo_o;
    if (n % 9 == 0) premix_o <= !premix_o;
  end
endmodule : vfomc_osc_model
`default_nettype wire

// File: tb/vfomc_top_sva.sv
// Purpose: port-level checks of vfomc_top
// Assumes: pins held two clocks per level
// Notes: latencies of three edges through the input synchronisers
`timescale 1ns/1ps
`default_nettype none
module vfomc_sva
  import vfomc_pkg::*;
#(parameter int SCAN_CYCLES = 4, parameter int OS_CYCLES = 3) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic xtal_ref_i,
  input wire logic variable_oscillator_i,
  input wire logic substitute_oscillator_i,
  input wire logic premix_lo_i,
  input wire logic memory_store_switch_i,
  input wire logic memory_recall_switch_i,
  input wire logic synth_feed_o,
  input wire logic recall_active_o,
  input wire logic stored_o,
  input wire logic divider_pulse_o,
  input wire logic phase_up_o,
  input wire logic phase_down_o,
  input wire logic [6:0] segment_o,
  input wire logic [DIGITS-1:0] digit_select_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [DIGITS-1:0] prev_dsel;
  logic [15:0] hold_cnt;
  logic [15:0] os_cnt;
  logic [2:0] up_cnt;
  // the zero after reset is not a digit, so the first move is not judged
  wire logic moved = digit_select_o != prev_dsel && prev_dsel != 6'h00;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_dsel <= 6'h00;
      hold_cnt <= 16'h0000;
      os_cnt <= 16'h0000;
      up_cnt <= 3'h0;
    end else begin
      prev_dsel <= digit_select_o;
      hold_cnt <= (digit_select_o != prev_dsel) ? 16'h0001 : hold_cnt + 16'h0001;
      os_cnt <= divider_pulse_o ? os_cnt + 16'h0001 : 16'h0000;
      up_cnt <= (up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1;
    end
  end
  AST_DSEL_ONEHOT: assert property (prev_dsel != 6'h00 |-> $onehot(digit_select_o))
    else $error("digit select not one-hot");
  AST_SCAN_ORDER: assert property (moved |-> digit_select_o ==
    (prev_dsel[5] ? 6'h01 : prev_dsel << 1)) else $error("digit scan out of order");
  AST_SCAN_HOLD: assert property (moved |-> hold_cnt == 16'(SCAN_CYCLES))
    else $error("digit shown for wrong time");
  // switch lines must settle through the synchronisers before the relation holds
  AST_FEED: assert property ((up_cnt == 3'h7 && $stable($past(memory_recall_switch_i, 3)))
    |-> synth_feed_o == ($past(memory_recall_switch_i, 3) ? $past(substitute_oscillator_i, 3)
    : $past(variable_oscillator_i, 3))) else $error("loop feed wrong source");
  AST_RECALL: assert property ((up_cnt == 3'h7 && $past(memory_recall_switch_i, 2) ==
    $past(memory_recall_switch_i, 3)) |-> recall_active_o == $past(memory_recall_switch_i, 2))
    else $error("recall flag wrong");
  AST_STORE_SET: assert property ($rose(memory_store_switch_i) |-> ##[1:5] stored_o)
    else $error("store press not taken");
  AST_STORE_HOLD: assert property (stored_o |=> stored_o)
    else $error("stored flag dropped");
  AST_OS_LEN: assert property ($fell(divider_pulse_o) |-> os_cnt == 16'(OS_CYCLES))
    else $error("one-shot length wrong");
  // a pending reference edge cancels against the divider edge instead of raising down
  AST_DOWN_TC: assert property ($rose(divider_pulse_o) |-> phase_down_o || $past(phase_up_o))
    else $error("divider edge missed by comparator");
  AST_PFD_BOTH: assert property (!(phase_up_o && phase_down_o))
    else $error("comparator not reset");
endmodule : vfomc_sva
bind vfomc_top vfomc_sva #(.SCAN_CYCLES(SCAN_CYCLES), .OS_CYCLES(OS_CYCLES)) u_sva (.clk_i,
  .rst_n_i, .xtal_ref_i, .variable_oscillator_i, .substitute_oscillator_i, .premix_lo_i,
  .memory_store_switch_i, .memory_recall_switch_i, .synth_feed_o, .recall_active_o, .stored_o,
  .divider_pulse_o, .phase_up_o, .phase_down_o, .segment_o, .digit_select_o);
`default_nettype wire

// File: tb/tb_vfo_frequency_memory_counter.sv
// Purpose: self-checking bench of vfomc_top
// Assumes: short scan and one-shot counts; a full counting window is beyond the run
// Notes: display hold stays zero, so every digit shows 0
`timescale 1ns/1ps
`default_nettype none
module tb_vfo_frequency_memory_counter
  import vfomc_pkg::*;
;
  localparam int SCAN = 4;
  localparam int OS = 3;
  typedef struct packed {logic rec; logic sub; logic act; logic feed; logic [5:0] dsel;} vfomc_row_t;
  vfomc_row_t rows [6] = '{{4'hf, 6'h02}, {4'ha, 6'h04}, {4'hf, 6'h08}, {4'h4, 6'h10},
    {4'h0, 6'h20}, {4'ha, 6'h01}};
  logic clk_i = 1'b0;
  logic rst_n_i, xtal_ref_i, variable_oscillator_i, substitute_oscillator_i, premix_lo_i;
  logic memory_store_switch_i, memory_recall_switch_i, synth_feed_o, recall_active_o, stored_o;
  logic divider_pulse_o, phase_up_o, phase_down_o;
  logic [6:0] segment_o;
  logic [5:0] digit_select_o;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  vfomc_osc_model u_osc (.clk_i, .xtal_o(xtal_ref_i), .vfo_o(variable_oscillator_i),
    .premix_o(premix_lo_i));
  vfomc_top #(.SCAN_CYCLES(SCAN), .OS_CYCLES(OS)) DUT (.clk_i, .rst_n_i, .xtal_ref_i,
    .variable_oscillator_i, .substitute_oscillator_i, .premix_lo_i, .memory_store_switch_i,
    .memory_recall_switch_i, .synth_feed_o, .recall_active_o, .stored_o, .divider_pulse_o,
    .phase_up_o, .phase_down_o, .segment_o, .digit_select_o);
  task check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task summarize;
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task ticks(input int n);
    repeat (n) @(negedge clk_i);
  endtask : ticks
  initial begin
    int t0;
    int k;
    rst_n_i = 1'b0;
    substitute_oscillator_i = 1'b0;
    memory_store_switch_i = 1'b0;
    memory_recall_switch_i = 1'b0;
    ticks(12);
    check({synth_feed_o, stored_o, divider_pulse_o, phase_down_o, digit_select_o,
      segment_o}, 24'h0);
    rst_n_i = 1'b1;
    t0 = cyc;
    ticks(1);
    check(24'(digit_select_o), 24'h01);
    check(24'(segment_o), 24'h3f);
    // first substitute edge loads the preset and fires one terminal count
    substitute_oscillator_i = 1'b1;
    for (k = 0; k < 10 && divider_pulse_o !== 1'b1; k++) ticks(1);
    check(24'(divider_pulse_o), 24'h1);
    check(24'(phase_down_o), 24'h1);
    for (k = 0; k < 20 && divider_pulse_o === 1'b1; k++) ticks(1);
    check(24'(k), 24'(OS));
    foreach (rows[i]) begin
      memory_recall_switch_i = rows[i].rec;
      substitute_oscillator_i = rows[i].sub;
      ticks(4);
      check(24'(recall_active_o), 24'(rows[i].act));
      if (rows[i].rec) check(24'(synth_feed_o), 24'(rows[i].feed));
      for (k = 0; k < 40 && digit_select_o !== rows[i].dsel; k++) ticks(1);
      check(24'(digit_select_o), 24'(rows[i].dsel));
      check(24'(segment_o), 24'h3f);
    end
    check(24'(stored_o), 24'h0);
    memory_store_switch_i = 1'b1;
    ticks(6);
    check(24'(stored_o), 24'h1);
    memory_store_switch_i = 1'b0;
    ticks(6);
    check(24'(stored_o), 24'h1);
    // down is pending from the divider edge; the first reference edge, after 2**REF_BIT
    // crystal rises of 4 clocks each plus sync latency, cancels it without raising up
    check(24'(phase_down_o), 24'h1);
    for (k = 0; k < 70000 && phase_down_o === 1'b1; k++) ticks(1);
    k = cyc - t0 - (1 << REF_BIT) * 4;
    check(24'(k >= 0 && k < 20), 24'h1);
    check(24'(phase_up_o), 24'h0);
    ticks(1);
    check(24'({phase_up_o, phase_down_o}), 24'h0);
    rst_n_i = 1'b0;
    ticks(2);
    check(24'({stored_o, digit_select_o}), 24'h0);
    rst_n_i = 1'b1;
    ticks(1);
    check(24'(digit_select_o), 24'h01);
    summarize();
  end
  initial begin
    repeat (80000) @(posedge clk_i);
    error_cnt++;
    summarize();
  end
endmodule : tb_vfo_frequency_memory_counter
`default_nettype wire
